/* File: hdl/prot_map_pkg.sv */
// constants and types shared by the protection switch action map
package prot_map_pkg;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam int ADDR_W = 6;
	localparam logic [ADDR_W-1:0] OFF_VC_ARM     = 6'h00;
	localparam logic [ADDR_W-1:0] OFF_TEMP_ARM   = 6'h04;
	localparam logic [ADDR_W-1:0] OFF_DSG_MASK   = 6'h08;
	localparam logic [ADDR_W-1:0] OFF_CHG_MASK   = 6'h0C;
	localparam logic [ADDR_W-1:0] OFF_BOTH_MASK  = 6'h10;
	localparam logic [ADDR_W-1:0] OFF_FLAGS      = 6'h14;
	localparam logic [ADDR_W-1:0] OFF_INT_STATUS = 6'h18;
	localparam logic [ADDR_W-1:0] OFF_INT_CLEAR  = 6'h1C;
	localparam logic [ADDR_W-1:0] OFF_INT_ENABLE = 6'h20;
	localparam logic [ADDR_W-1:0] OFF_SWITCH     = 6'h24;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] RST_VC_ARM    = 8'hA1;
	localparam logic [7:0] RST_TEMP_ARM  = 8'h00;
	localparam logic [7:0] RST_DSG_MASK  = 8'hFF;
	localparam logic [7:0] RST_CHG_MASK  = 8'hEF;
	localparam logic [7:0] RST_BOTH_MASK = 8'h06;

	// ------------------------------------------------------------
	// safety flag word: low byte follows the voltage/current arm
	// ------------------------------------------------------------
	localparam int FL_W = 16;
	typedef logic [FL_W-1:0] flag_vec_t;
	localparam int F_COV   = 7;
	localparam int F_CUV   = 6;
	localparam int F_SCD   = 5;
	localparam int F_DISCHARGE_OVERCURRENT_ONE  = 4;
	localparam int F_DISCHARGE_OVERCURRENT_TWO  = 3;
	localparam int F_OCC   = 2;
	localparam int F_CURL  = 1;
	localparam int F_REGCK = 0;
	localparam int F_INTERNAL_OVERTEMP = 9;
	localparam int F_UTC   = 10;
	localparam int F_UTD   = 11;
	localparam int F_OTC   = 12;
	localparam int F_OTD   = 13;
	localparam int F_GND   = 14;
	localparam int F_REF   = 15;

	// temperature arm field span within the temperature arm register
	localparam int TA_LO = 1;
	localparam int TA_HI = 5;

	// ------------------------------------------------------------
	// switch mask bit positions
	// ------------------------------------------------------------
	localparam int M_DSG_CUV = 7;
	localparam int M_DSG_SCD = 6;
	localparam int M_DSG_OD1 = 5;
	localparam int M_DSG_OD2 = 4;
	localparam int M_DSG_OTD = 2;
	localparam int M_DSG_UTD = 1;
	localparam int M_DSG_OTI = 0;
	localparam int M_CHG_COV = 7;
	localparam int M_CHG_SCD = 6;
	localparam int M_CHG_OCC = 5;
	localparam int M_CHG_OTC = 2;
	localparam int M_CHG_UTC = 1;
	localparam int M_CHG_OTI = 0;
	localparam int M_BOTH_REF = 2;
	localparam int M_BOTH_GND = 1;
	localparam int M_BOTH_REG = 0;

	// ------------------------------------------------------------
	// bus answers
	// ------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [3:0] {
		RI_VC_ARM, RI_TEMP_ARM, RI_DSG_MASK, RI_CHG_MASK, RI_BOTH_MASK,
		RI_FLAGS, RI_INT_STATUS, RI_INT_CLEAR, RI_INT_ENABLE, RI_SWITCH,
		RI_NONE
	} reg_idx_t;

endpackage

/* File: hdl/fault_arm_gate.sv */
// registered gating of raw fault detections by their arming bits
module fault_arm_gate #(
	parameter int W = 16
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// detections and arming
	input  wire logic [W-1:0] fault,
	input  wire logic [W-1:0] arm,
	// safety flags
	output logic      [W-1:0] flag
);

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk) begin
				if (rst) begin
					flag[i] <= 1'b0;
				end else begin
					flag[i] <= fault[i] & arm[i];
				end
			end
		end
	endgenerate

endmodule

/* File: hdl/switch_action_map.sv */
// routes safety flags through the three switch masks
module switch_action_map
	import prot_map_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// flags and masks
	input  wire flag_vec_t  flag,
	input  wire logic [7:0] dsg_mask,
	input  wire logic [7:0] chg_mask,
	input  wire logic [7:0] both_mask,
	// switch off requests
	output logic            dsg_off,
	output logic            chg_off
);

	logic dsg_hit;
	logic chg_hit;
	logic both_hit;

	// only named mask bits are looked at; reserved ones stay inert
	assign dsg_hit = (flag[F_CUV]   & dsg_mask[M_DSG_CUV])
		| (flag[F_SCD]   & dsg_mask[M_DSG_SCD])
		| (flag[F_DISCHARGE_OVERCURRENT_ONE]  & dsg_mask[M_DSG_OD1])
		| (flag[F_DISCHARGE_OVERCURRENT_TWO]  & dsg_mask[M_DSG_OD2])
		| (flag[F_OTD]   & dsg_mask[M_DSG_OTD])
		| (flag[F_UTD]   & dsg_mask[M_DSG_UTD])
		| (flag[F_INTERNAL_OVERTEMP] & dsg_mask[M_DSG_OTI]);
	assign chg_hit = (flag[F_COV]   & chg_mask[M_CHG_COV])
		| (flag[F_SCD]   & chg_mask[M_CHG_SCD])
		| (flag[F_OCC]   & chg_mask[M_CHG_OCC])
		| (flag[F_OTC]   & chg_mask[M_CHG_OTC])
		| (flag[F_UTC]   & chg_mask[M_CHG_UTC])
		| (flag[F_INTERNAL_OVERTEMP] & chg_mask[M_CHG_OTI]);
	assign both_hit = (flag[F_REF] & both_mask[M_BOTH_REF])
		| (flag[F_GND]   & both_mask[M_BOTH_GND])
		| (flag[F_REGCK] & both_mask[M_BOTH_REG]);

	always_ff @(posedge clk) begin
		if (rst) begin
			dsg_off <= 1'b0;
			chg_off <= 1'b0;
		end else begin
			dsg_off <= dsg_hit | both_hit;
			chg_off <= chg_hit | both_hit;
		end
	end

endmodule

/* File: hdl/protection_fet_action_map.sv */
// protection arming, switch action masks and their register bank
// Function
// - armed protection sets its flag, unarmed never
// - temperature arm bits five down to one
// - three independent masks decide switch action
// - discharge mask layout, reset FF
// - set discharge bit turns discharge switch off
// - charge mask layout, reset EF
// - both-switch mask layout, reset 06
// - voltage/current arm layout, reset A1
module protection_fet_action_map
	import prot_map_pkg::*;
(
	// clock and reset
	input  wire logic              MCLK,
	input  wire logic              RESET,
	// write address channel
	input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
	input  wire logic [2:0]        S_AXI_AWPROT,
	input  wire logic              S_AXI_AWVALID,
	output logic                   S_AXI_AWREADY,
	// write data channel
	input  wire logic [31:0]       S_AXI_WDATA,
	input  wire logic [3:0]        S_AXI_WSTRB,
	input  wire logic              S_AXI_WVALID,
	output logic                   S_AXI_WREADY,
	// write response channel
	output logic [1:0]             S_AXI_BRESP,
	output logic                   S_AXI_BVALID,
	input  wire logic              S_AXI_BREADY,
	// read address channel
	input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
	input  wire logic [2:0]        S_AXI_ARPROT,
	input  wire logic              S_AXI_ARVALID,
	output logic                   S_AXI_ARREADY,
	// read data channel
	output logic [31:0]            S_AXI_RDATA,
	output logic [1:0]             S_AXI_RRESP,
	output logic                   S_AXI_RVALID,
	input  wire logic              S_AXI_RREADY,
	// fault detections, voltage and current
	input  wire logic              CELL_OVERVOLTAGE,
	input  wire logic              CELL_UNDERVOLTAGE,
	input  wire logic              SHORT_CIRCUIT,
	input  wire logic              DISCHARGE_OVERCURRENT_ONE,
	input  wire logic              DISCHARGE_OVERCURRENT_TWO,
	input  wire logic              CHARGE_OVERCURRENT,
	input  wire logic              CURRENT_LATCH,
	input  wire logic              REGULATOR_OUTPUT_CHECK,
	// fault detections, temperature
	input  wire logic              DISCHARGE_OVERTEMP,
	input  wire logic              CHARGE_OVERTEMP,
	input  wire logic              DISCHARGE_UNDERTEMP,
	input  wire logic              CHARGE_UNDERTEMP,
	input  wire logic              INTERNAL_OVERTEMP,
	// fault detections, diagnostics
	input  wire logic              REFERENCE_DIAG,
	input  wire logic              GROUND_DIAG,
	// safety flags and switch control
	output flag_vec_t              SAFETY_FLAGS,
	output logic                   DISCHARGE_SWITCH_OFF,
	output logic                   CHARGE_SWITCH_OFF,
	// interrupt
	output logic                   IRQ
);

	import prot_map_pkg::*;

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	function automatic reg_idx_t reg_sel(input logic [ADDR_W-1:0] a);
		case (a)
			OFF_VC_ARM:     reg_sel = RI_VC_ARM;
			OFF_TEMP_ARM:   reg_sel = RI_TEMP_ARM;
			OFF_DSG_MASK:   reg_sel = RI_DSG_MASK;
			OFF_CHG_MASK:   reg_sel = RI_CHG_MASK;
			OFF_BOTH_MASK:  reg_sel = RI_BOTH_MASK;
			OFF_FLAGS:      reg_sel = RI_FLAGS;
			OFF_INT_STATUS: reg_sel = RI_INT_STATUS;
			OFF_INT_CLEAR:  reg_sel = RI_INT_CLEAR;
			OFF_INT_ENABLE: reg_sel = RI_INT_ENABLE;
			OFF_SWITCH:     reg_sel = RI_SWITCH;
			default:        reg_sel = RI_NONE;
		endcase
	endfunction

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic              aw_held_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic              w_held_q;
	logic [31:0]       wdata_q;
	logic [3:0]        wstrb_q;
	logic              bvalid_q;
	logic [1:0]        bresp_q;
	logic              rvalid_q;
	logic [1:0]        rresp_q;
	logic [31:0]       rdata_q;
	logic [31:0]       rdata_d;
	logic [1:0]        rresp_d;
	logic              do_write;
	logic              do_read;
	reg_idx_t          wsel;
	reg_idx_t          rsel;
	logic              lo_en;
	logic              hi_en;

	logic [7:0]        vc_arm_q;
	logic [7:0]        temp_arm_q;
	logic [7:0]        dsg_mask_q;
	logic [7:0]        chg_mask_q;
	logic [7:0]        both_mask_q;
	flag_vec_t         int_en_q;
	flag_vec_t         int_stat_q;
	flag_vec_t         int_clr;
	logic              irq_q;

	flag_vec_t         fault_vec;
	flag_vec_t         arm_vec;
	flag_vec_t         flags;
	logic              dsg_off;
	logic              chg_off;

	// ------------------------------------------------------------
	// write channels
	// ------------------------------------------------------------
	// address and data are caught independently and joined later
	assign S_AXI_AWREADY = !aw_held_q;
	assign S_AXI_WREADY  = !w_held_q;
	assign do_write      = aw_held_q && w_held_q && !bvalid_q;
	assign wsel          = reg_sel(awaddr_q);
	assign lo_en         = do_write && wstrb_q[0];
	assign hi_en         = do_write && wstrb_q[1];

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			aw_held_q <= 1'b0;
			awaddr_q  <= '0;
		end else if (S_AXI_AWVALID && !aw_held_q) begin
			aw_held_q <= 1'b1;
			awaddr_q  <= S_AXI_AWADDR;
		end else if (do_write) begin
			aw_held_q <= 1'b0;
		end
	end

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			w_held_q <= 1'b0;
			wdata_q  <= '0;
			wstrb_q  <= '0;
		end else if (S_AXI_WVALID && !w_held_q) begin
			w_held_q <= 1'b1;
			wdata_q  <= S_AXI_WDATA;
			wstrb_q  <= S_AXI_WSTRB;
		end else if (do_write) begin
			w_held_q <= 1'b0;
		end
	end

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end else if (do_write) begin
			bvalid_q <= 1'b1;
			bresp_q  <= (wsel == RI_NONE) ? RESP_SLVERR : RESP_OKAY;
		end else if (S_AXI_BREADY) begin
			bvalid_q <= 1'b0;
		end
	end

	assign S_AXI_BVALID = bvalid_q;
	assign S_AXI_BRESP  = bresp_q;

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	// all eight bits are stored; reserved bits read back as written
	// and are simply never routed into the switch logic
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			vc_arm_q <= RST_VC_ARM;
		end else if (lo_en && wsel == RI_VC_ARM) begin
			vc_arm_q <= wdata_q[7:0];
		end
	end

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			temp_arm_q <= RST_TEMP_ARM;
		end else if (lo_en && wsel == RI_TEMP_ARM) begin
			temp_arm_q <= wdata_q[7:0];
		end
	end

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			dsg_mask_q <= RST_DSG_MASK;
		end else if (lo_en && wsel == RI_DSG_MASK) begin
			dsg_mask_q <= wdata_q[7:0];
		end
	end

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			chg_mask_q <= RST_CHG_MASK;
		end else if (lo_en && wsel == RI_CHG_MASK) begin
			chg_mask_q <= wdata_q[7:0];
		end
	end

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			both_mask_q <= RST_BOTH_MASK;
		end else if (lo_en && wsel == RI_BOTH_MASK) begin
			both_mask_q <= wdata_q[7:0];
		end
	end

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			int_en_q <= '0;
		end else if (do_write && wsel == RI_INT_ENABLE) begin
			if (wstrb_q[0]) begin
				int_en_q[7:0] <= wdata_q[7:0];
			end
			if (wstrb_q[1]) begin
				int_en_q[15:8] <= wdata_q[15:8];
			end
		end
	end

	// ------------------------------------------------------------
	// fault arming
	// ------------------------------------------------------------
	assign fault_vec[F_COV]   = CELL_OVERVOLTAGE;
	assign fault_vec[F_CUV]   = CELL_UNDERVOLTAGE;
	assign fault_vec[F_SCD]   = SHORT_CIRCUIT;
	assign fault_vec[F_DISCHARGE_OVERCURRENT_ONE]  = DISCHARGE_OVERCURRENT_ONE;
	assign fault_vec[F_DISCHARGE_OVERCURRENT_TWO]  = DISCHARGE_OVERCURRENT_TWO;
	assign fault_vec[F_OCC]   = CHARGE_OVERCURRENT;
	assign fault_vec[F_CURL]  = CURRENT_LATCH;
	assign fault_vec[F_REGCK] = REGULATOR_OUTPUT_CHECK;
	assign fault_vec[8]       = 1'b0;
	assign fault_vec[F_INTERNAL_OVERTEMP] = INTERNAL_OVERTEMP;
	assign fault_vec[F_UTC]   = CHARGE_UNDERTEMP;
	assign fault_vec[F_UTD]   = DISCHARGE_UNDERTEMP;
	assign fault_vec[F_OTC]   = CHARGE_OVERTEMP;
	assign fault_vec[F_OTD]   = DISCHARGE_OVERTEMP;
	assign fault_vec[F_GND]   = GROUND_DIAG;
	assign fault_vec[F_REF]   = REFERENCE_DIAG;

	// the diagnostics carry no arming bit and are always live;
	// reserved temperature arm bits are dropped here
	assign arm_vec[7:0]       = vc_arm_q;
	assign arm_vec[8]         = 1'b0;
	assign arm_vec[F_OTD:F_INTERNAL_OVERTEMP] = temp_arm_q[TA_HI:TA_LO];
	assign arm_vec[F_GND]     = 1'b1;
	assign arm_vec[F_REF]     = 1'b1;

	fault_arm_gate #(
		.W     (FL_W)
	) u_arm (
		.clk   (MCLK),
		.rst   (RESET),
		.fault (fault_vec),
		.arm   (arm_vec),
		.flag  (flags)
	);

	// ------------------------------------------------------------
	// switch action
	// ------------------------------------------------------------
	// masks act on flags only, so arming and action stay separate
	switch_action_map u_map (
		.clk       (MCLK),
		.rst       (RESET),
		.flag      (flags),
		.dsg_mask  (dsg_mask_q),
		.chg_mask  (chg_mask_q),
		.both_mask (both_mask_q),
		.dsg_off   (dsg_off),
		.chg_off   (chg_off)
	);

	assign SAFETY_FLAGS         = flags;
	assign DISCHARGE_SWITCH_OFF = dsg_off;
	assign CHARGE_SWITCH_OFF    = chg_off;

	// ------------------------------------------------------------
	// interrupt status
	// ------------------------------------------------------------
	always_comb begin
		int_clr = '0;
		if (do_write && wsel == RI_INT_CLEAR) begin
			if (wstrb_q[0]) begin
				int_clr[7:0] = wdata_q[7:0];
			end
			if (hi_en) begin
				int_clr[15:8] = wdata_q[15:8];
			end
		end
	end

	// a flag raised in the clearing cycle keeps its status bit
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			int_stat_q <= '0;
		end else begin
			int_stat_q <= (int_stat_q & ~int_clr) | flags;
		end
	end

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(int_stat_q & int_en_q);
		end
	end

	assign IRQ = irq_q;

	// ------------------------------------------------------------
	// read channels
	// ------------------------------------------------------------
	assign S_AXI_ARREADY = !rvalid_q;
	assign do_read       = S_AXI_ARVALID && !rvalid_q;
	assign rsel          = reg_sel(S_AXI_ARADDR);

	always_comb begin
		rdata_d = '0;
		rresp_d = RESP_OKAY;
		case (rsel)
			RI_VC_ARM:     rdata_d[7:0] = vc_arm_q;
			RI_TEMP_ARM:   rdata_d[7:0] = temp_arm_q;
			RI_DSG_MASK:   rdata_d[7:0] = dsg_mask_q;
			RI_CHG_MASK:   rdata_d[7:0] = chg_mask_q;
			RI_BOTH_MASK:  rdata_d[7:0] = both_mask_q;
			RI_FLAGS:      rdata_d[FL_W-1:0] = flags;
			RI_INT_STATUS: rdata_d[FL_W-1:0] = int_stat_q;
			RI_INT_ENABLE: rdata_d[FL_W-1:0] = int_en_q;
			RI_SWITCH:     rdata_d[1:0] = {chg_off, dsg_off};
			RI_INT_CLEAR:  rdata_d = '0;
			default:       rresp_d = RESP_SLVERR;
		endcase
	end

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			rvalid_q <= 1'b0;
			rdata_q  <= '0;
			rresp_q  <= RESP_OKAY;
		end else if (do_read) begin
			rvalid_q <= 1'b1;
			rdata_q  <= rdata_d;
			rresp_q  <= rresp_d;
		end else if (S_AXI_RREADY) begin
			rvalid_q <= 1'b0;
		end
	end

	assign S_AXI_RVALID = rvalid_q;
	assign S_AXI_RDATA  = rdata_q;
	assign S_AXI_RRESP  = rresp_q;

endmodule

/* File: tb/fault_detectors.sv */
// behavioural protection detectors driving the fault inputs
module fault_detectors
	import prot_map_pkg::*;
(
	// clock
	input  wire logic      clk,
	// requested fault levels and detector levels
	input  wire flag_vec_t want,
	output flag_vec_t      det
);
	timeunit 1ns;
	timeprecision 1ps;
	// levels change on an edge; slot 8 has no detector behind it
	always @(posedge clk) begin
		det <= want & 16'hFEFF;
	end
endmodule

/* File: tb/protection_fet_action_map_props.sv */
// concurrent checks on the action map's bus and flag outputs
module protection_fet_action_map_props
	import prot_map_pkg::*;
(
	// clock and reset
	input wire logic        MCLK,
	input wire logic        RESET,
	// register bus
	input wire logic        S_AXI_AWVALID,
	input wire logic        S_AXI_AWREADY,
	input wire logic        S_AXI_WVALID,
	input wire logic        S_AXI_WREADY,
	input wire logic [1:0]  S_AXI_BRESP,
	input wire logic        S_AXI_BVALID,
	input wire logic        S_AXI_BREADY,
	input wire logic        S_AXI_ARVALID,
	input wire logic        S_AXI_ARREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic        S_AXI_RVALID,
	input wire logic        S_AXI_RREADY,
	// detections and outputs
	input wire logic        CELL_OVERVOLTAGE,
	input wire logic        REFERENCE_DIAG,
	input wire logic        GROUND_DIAG,
	input wire flag_vec_t   SAFETY_FLAGS,
	input wire logic        DISCHARGE_SWITCH_OFF,
	input wire logic        CHARGE_SWITCH_OFF
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (RESET);
	sequence wr_take;
		S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
	endsequence
	sequence wr_answer;
		(!S_AXI_AWREADY && !S_AXI_WREADY) ##1 S_AXI_BVALID;
	endsequence
	sequence rd_take;
		S_AXI_ARVALID && S_AXI_ARREADY;
	endsequence
	write_answer_a: assert property (wr_take |=> wr_answer)
		else $error("write answer late or readies not dropped");
	read_answer_a: assert property (rd_take |=> S_AXI_RVALID && !S_AXI_ARREADY)
		else $error("read answer missing after address taken");
	bresp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY
		|=> S_AXI_BVALID && $stable(S_AXI_BRESP))
		else $error("write response dropped before taken");
	rdata_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY
		|=> S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("read data dropped before taken");
	// diagnostics have no arming bit, so their flags track exactly
	diag_flag_a: assert property (!$past(RESET) |->
		SAFETY_FLAGS[F_REF:F_GND] == $past({REFERENCE_DIAG, GROUND_DIAG}))
		else $error("diagnostic flag not following its detection");
	flag_cause_a: assert property (SAFETY_FLAGS[F_COV] |->
		$past(CELL_OVERVOLTAGE))
		else $error("flag raised without its detection");
	dsg_cause_a: assert property (DISCHARGE_SWITCH_OFF |->
		$past(SAFETY_FLAGS) != 16'h0000)
		else $error("discharge switch off with no flag");
	chg_cause_a: assert property (CHARGE_SWITCH_OFF |->
		$past(SAFETY_FLAGS) != 16'h0000)
		else $error("charge switch off with no flag");
endmodule

bind protection_fet_action_map protection_fet_action_map_props props_inst (
	.MCLK(MCLK), .RESET(RESET), .S_AXI_AWVALID(S_AXI_AWVALID),
	.S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
	.S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
	.S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
	.S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
	.S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
	.S_AXI_RREADY(S_AXI_RREADY), .CELL_OVERVOLTAGE(CELL_OVERVOLTAGE),
	.REFERENCE_DIAG(REFERENCE_DIAG), .GROUND_DIAG(GROUND_DIAG),
	.SAFETY_FLAGS(SAFETY_FLAGS), .CHARGE_SWITCH_OFF(CHARGE_SWITCH_OFF),
	.DISCHARGE_SWITCH_OFF(DISCHARGE_SWITCH_OFF)
);

/* File: tb/protection_fet_action_map_tb.sv */
// self-checking bench for the protection switch action map
module protection_fet_action_map_tb
	import prot_map_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [5:0]  awaddr = 6'h00;
	logic [5:0]  araddr = 6'h00;
	logic [31:0] wdata = 32'h0;
	logic        awv = 1'b0;
	logic        wv = 1'b0;
	logic        bready = 1'b0;
	logic        arv = 1'b0;
	logic        rready = 1'b0;
	flag_vec_t   want = 16'h0;
	flag_vec_t   det;
	flag_vec_t   flags;
	logic        awready, wready, bvalid, arready, rvalid;
	logic        dsg_off, chg_off, irq;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	int          bad_count = 0;
	int          checked = 0;
	int          cyc = 0;

	fault_detectors fault_detectors_inst (.clk(clk), .want(want), .det(det));
	protection_fet_action_map protection_fet_action_map_inst (
		.MCLK(clk), .RESET(rst), .S_AXI_AWADDR(awaddr),
		.S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0),
		.S_AXI_ARVALID(arv), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.CELL_OVERVOLTAGE(det[F_COV]), .CELL_UNDERVOLTAGE(det[F_CUV]),
		.SHORT_CIRCUIT(det[F_SCD]), .DISCHARGE_OVERCURRENT_ONE(det[F_DISCHARGE_OVERCURRENT_ONE]),
		.DISCHARGE_OVERCURRENT_TWO(det[F_DISCHARGE_OVERCURRENT_TWO]),
		.CHARGE_OVERCURRENT(det[F_OCC]), .CURRENT_LATCH(det[F_CURL]),
		.REGULATOR_OUTPUT_CHECK(det[F_REGCK]),
		.DISCHARGE_OVERTEMP(det[F_OTD]), .CHARGE_OVERTEMP(det[F_OTC]),
		.DISCHARGE_UNDERTEMP(det[F_UTD]), .CHARGE_UNDERTEMP(det[F_UTC]),
		.INTERNAL_OVERTEMP(det[F_INTERNAL_OVERTEMP]), .REFERENCE_DIAG(det[F_REF]),
		.GROUND_DIAG(det[F_GND]), .SAFETY_FLAGS(flags),
		.DISCHARGE_SWITCH_OFF(dsg_off), .CHARGE_SWITCH_OFF(chg_off), .IRQ(irq)
	);

	// ------------------------------------------------------------
	// clock, timeout and verdict
	// ------------------------------------------------------------
	always #2.5 clk = ~clk;
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			$display("ERROR t=%0t run did not finish", $time);
			wrap_up();
		end
	end

	// ------------------------------------------------------------
	// bus tasks and expectations
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got %h expected %h", $time, got, exp);
		end
	endtask
	// ready is held back a few cycles so the slave must hold its answer
	task automatic wr(input logic [5:0] a, input logic [31:0] d,
			output logic [1:0] r);
		logic ta, tw, tb, sa, sw;
		int n;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		tb = 1'b0;
		sa = 1'b0;
		sw = 1'b0;
		n = 0;
		// the wait ends once the write response is taken; only the bench timeout ends it otherwise
		while (!tb) begin
			@(negedge clk);
			ta = awv && (awready === 1'b1);
			tw = wv && (wready === 1'b1);
			tb = bready && (bvalid === 1'b1);
			sa = sa | ta;
			sw = sw | tw;
			r = bresp;
			n++;
			@(posedge clk);
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
			if (n == 3) bready <= 1'b1;
		end
		bready <= 1'b0;
		// the answer must follow both address and data
		chk({30'h0, sa, sw}, 32'h3);
	endtask
	task automatic rd(input logic [5:0] a, output logic [31:0] d,
			output logic [1:0] r);
		logic ta, tr, sa;
		int n;
		@(posedge clk);
		araddr <= a;
		arv <= 1'b1;
		tr = 1'b0;
		sa = 1'b0;
		n = 0;
		while (!tr) begin
			@(negedge clk);
			ta = arv && (arready === 1'b1);
			tr = rready && (rvalid === 1'b1);
			sa = sa | ta;
			d = rdata;
			r = rresp;
			n++;
			@(posedge clk);
			if (ta) arv <= 1'b0;
			if (n == 3) rready <= 1'b1;
		end
		rready <= 1'b0;
		chk({31'h0, sa}, 32'h1);
	endtask
	task automatic rdchk(input logic [5:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(d, e);
		chk({30'h0, r}, {30'h0, RESP_OKAY});
	endtask
	task automatic cfg(input logic [5:0] a, input logic [7:0] v);
		logic [1:0] r;
		wr(a, {24'h0, v}, r);
		chk({30'h0, r}, {30'h0, RESP_OKAY});
	endtask
	function automatic flag_vec_t exp_flags(flag_vec_t f, logic [7:0] va,
			logic [7:0] ta);
		return f & 16'hFEFF & {2'b11, ta[5:1], 1'b0, va};
	endfunction
	function automatic logic [1:0] exp_off(flag_vec_t g, logic [7:0] dm,
			logic [7:0] cm, logic [7:0] bm);
		logic b, d, c;
		b = |(bm[2:0] & {g[F_REF], g[F_GND], g[F_REGCK]});
		d = |(dm & {g[F_CUV], g[F_SCD], g[F_DISCHARGE_OVERCURRENT_ONE], g[F_DISCHARGE_OVERCURRENT_TWO], 1'b0,
			g[F_OTD], g[F_UTD], g[F_INTERNAL_OVERTEMP]});
		c = |(cm & {g[F_COV], g[F_SCD], g[F_OCC], 2'b00,
			g[F_OTC], g[F_UTC], g[F_INTERNAL_OVERTEMP]});
		return {c | b, d | b};
	endfunction

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		logic [7:0] va, ta, dm, cm, bm;
		logic [63:0] rv;
		flag_vec_t f, g;
		logic [1:0] o;
		logic [31:0] d;
		logic [1:0] r;
		void'($urandom(32'hE387E515));
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rdchk(OFF_VC_ARM, 32'h000000A1);
		rdchk(OFF_TEMP_ARM, 32'h00000000);
		rdchk(OFF_DSG_MASK, 32'h000000FF);
		rdchk(OFF_CHG_MASK, 32'h000000EF);
		rdchk(OFF_BOTH_MASK, 32'h00000006);
		$display("test reset values done");
		{va, ta, dm, cm, bm} = 40'hA1_00_FF_EF_06;
		// pass 0 keeps reset masks, pass 1 arms all with masks clear
		for (int i = 0; i < 60; i++) begin
			rv = {$urandom, $urandom};
			if (i == 1) {va, ta, dm, cm, bm} = 40'hFF_FF_00_00_00;
			if (i > 1) {va, ta, dm, cm, bm} = rv[39:0];
			if (i > 0) begin
				cfg(OFF_VC_ARM, va);
				cfg(OFF_TEMP_ARM, ta);
				cfg(OFF_DSG_MASK, dm);
				cfg(OFF_CHG_MASK, cm);
				cfg(OFF_BOTH_MASK, bm);
			end
			f = (i % 3 == 0) ? 16'h1 << rv[43:40] : rv[63:48];
			@(posedge clk);
			want <= f;
			repeat (4) @(posedge clk);
			@(negedge clk);
			g = exp_flags(f, va, ta);
			o = exp_off(g, dm, cm, bm);
			chk({16'h0, flags}, {16'h0, g});
			chk({30'h0, chg_off, dsg_off}, {30'h0, o});
			rdchk(OFF_FLAGS, {16'h0, g});
			rdchk(OFF_SWITCH, {30'h0, o});
			rdchk(OFF_DSG_MASK, {24'h0, dm});
			rdchk(OFF_TEMP_ARM, {24'h0, ta});
		end
		want <= 16'h0;
		$display("test arming and switch masks done");
		wr(6'h3C, 32'h000000FF, r);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		rd(6'h3C, d, r);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		chk(d, 32'h0);
		cfg(OFF_SWITCH, 8'h03);
		rdchk(OFF_SWITCH, 32'h0);
		$display("test unmapped and read-only done");
		cfg(OFF_INT_CLEAR, 8'hFF);
		wr(OFF_INT_CLEAR, 32'h0000FF00, r);
		wr(OFF_INT_ENABLE, 32'h00008000, r);
		rdchk(OFF_INT_ENABLE, 32'h00008000);
		// sample the level mid-cycle, away from the edge that moves it
		@(negedge clk);
		chk({31'h0, irq}, 32'h0);
		@(posedge clk);
		want <= 16'h8000;
		repeat (5) @(posedge clk);
		want <= 16'h0;
		repeat (5) @(posedge clk);
		@(negedge clk);
		chk({31'h0, irq}, 32'h1);
		rdchk(OFF_INT_STATUS, 32'h00008000);
		wr(OFF_INT_ENABLE, 32'h0, r);
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk({31'h0, irq}, 32'h0);
		wr(OFF_INT_CLEAR, 32'h00008000, r);
		rdchk(OFF_INT_STATUS, 32'h0);
		$display("test interrupt done");
		wrap_up();
	end
endmodule
